// File: src/psc_pkg.sv
// Purpose: Shared constants for the power and system control register block.
// Assumes: 100 MHz ref_clk, Avalon-MM word addressing (index = word address).
// Notes:   Summary of operation is listed below; tags appear in the module bodies.
//
// Summary of operation
// R1 - With the diagnostic map bit set, pin 2 drives the reference-on state and pin 1 the woken-up flag.
// R2 - The debug host must detach before sleep with the diagnostic map set, since pin 2 is its clock.
// R3 - A two-bit field picks the bus clock divider used while memory is mirrored into RAM.
// R4 - A read/write bit, one after reset, holds the radio digital part powered down.
// R5 - A read/write bit, one after reset, holds the timer power domain powered down.
// R6 - With the reset-after-wake bit set, waking from sleep triggers a hardware reset.
// R7 - Writing one to bit 15 of system control resets the device except that register and trim.
// R8 - The power sequencer gives up waiting for analog start after 2 ms unless timeout is disabled.
// R9 - Debug code 0 is off, code 1 puts clock on pin 2 and data on pin 5, code 2 data on pin 1.
// R10 - Boot code loads the debug field; while it is zero the debug pins are plain GPIO.
// R11 - Debug code 3 puts the clock on pin 2 and data on pin 10.
// R12 - A read-only status bit shows one while a debug host is attached to the core.
// R13 - Reserved read/write bits store and return written values and do nothing else.
package psc_pkg;

  // Register addresses; the bus word address is the low bits of each
  localparam logic [31:0] PUC_IDX  = 32'h5000_0010;
  localparam logic [31:0] SC_IDX   = 32'h5000_0012;
  localparam logic [31:0] STAT_IDX = 32'h5000_0014;

  // Power unit control fields
  localparam int          PUC_DIAG_BIT  = 6;
  localparam int          PUC_DIV_LSB   = 4;
  localparam int          PUC_RADIO_BIT = 2;
  localparam int          PUC_TIMER_BIT = 1;
  localparam int          PUC_RAW_BIT   = 0;
  localparam logic [15:0] PUC_RESET     = 16'h0006;
  localparam logic [15:0] PUC_RW_MASK   = 16'h007F;

  // System control fields
  localparam int          SC_SWRST_BIT = 15;
  localparam int          SC_TMO_BIT   = 10;
  localparam int          SC_DBG_LSB   = 7;
  localparam logic [15:0] SC_RESET     = 16'h0020;
  localparam logic [15:0] SC_RW_MASK   = 16'h07FF;

  // Status fields
  localparam int STAT_TMO_BIT = 8;
  localparam int STAT_DBG_BIT = 4;
  localparam int STAT_TUP_BIT = 3;
  localparam int STAT_TDN_BIT = 2;
  localparam int STAT_RUP_BIT = 1;
  localparam int STAT_RDN_BIT = 0;

  // Debug routing codes and pins
  localparam logic [1:0] DBG_OFF   = 2'h0;
  localparam logic [1:0] DBG_PIN5  = 2'h1;
  localparam logic [1:0] DBG_PIN1  = 2'h2;
  localparam logic [1:0] DBG_PIN10 = 2'h3;
  localparam int         CLK_PIN   = 2;
  localparam int         WOKE_PIN  = 1;

  // Analog start-up timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIMEOUT_MS    = 2;
  localparam int TIMEOUT_CYC   = (TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

  // Power sequencer states
  typedef enum logic [2:0] {
    PSC_IDLE = 3'b001,
    PSC_WAIT = 3'b010,
    PSC_DONE = 3'b100
  } psc_state_e;

endpackage : psc_pkg

// File: src/psc_pwr_seq.sv
// Purpose: Power sequencer step that waits for the analog blocks to start.
// Assumes: start is a one-cycle pulse; analog_ready is synchronous.
// Notes:   A start while busy is ignored.
module psc_pwr_seq
  import psc_pkg::*;
#(
  parameter int CNT_W   = 18,
  parameter int TMO_CYC = TIMEOUT_CYC
)(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic analog_ready,
  input  wire logic timeout_disable,
  // Status
  output logic      busy,
  output logic      done,
  output logic      timed_out
);

  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TMO_CYC - 1);

  psc_state_e       state_q;
  psc_state_e       state_d;
  logic [CNT_W-1:0] cnt_q;
  wire              expired;

  // R8 timeout unless disabled
  assign expired = !timeout_disable && (cnt_q == CNT_LAST);

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PSC_IDLE: if (start) state_d = PSC_WAIT;
      PSC_WAIT: if (analog_ready || expired) state_d = PSC_DONE;
      PSC_DONE: state_d = PSC_IDLE;
      default:  state_d = PSC_IDLE;
    endcase
  end

  // State and wait counter
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= PSC_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= (state_q == PSC_WAIT) ? cnt_q + 1'b1 : '0;
    end
  end

  // Timeout flag holds until the next start
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      timed_out <= 1'b0;
    else if (state_q == PSC_WAIT && !analog_ready && expired)
      timed_out <= 1'b1;
    else if (state_q == PSC_IDLE && start)
      timed_out <= 1'b0;
  end

  assign busy = (state_q == PSC_WAIT);
  assign done = (state_q == PSC_DONE);

endmodule : psc_pwr_seq

// File: src/psc_top.sv
// Purpose: Power unit and system control registers with pin routing.
// Assumes: Avalon-MM slave with one wait state, word addressing, 32-bit data.
// Notes:   Pin outputs lag their causes by one clock; all outputs are flopped.
//
// Design decision made here: the Avalon-MM register port.
module psc_top
  import psc_pkg::*;
#(
  parameter int ADDR_W   = 8,
  parameter int NUM_P0   = 11,
  parameter int TMO_CYC  = TIMEOUT_CYC,
  parameter int CNT_W    = 18
)(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Port 0 pads
  input  wire logic [NUM_P0-1:0] p0_in,
  output logic      [NUM_P0-1:0] p0_out,
  output logic      [NUM_P0-1:0] p0_oe,
  // GPIO controller side
  input  wire logic [NUM_P0-1:0] gpio_out,
  input  wire logic [NUM_P0-1:0] gpio_oe,
  output logic      [NUM_P0-1:0] gpio_in,
  // Debug port side
  input  wire logic              dbg_dio_out,
  input  wire logic              dbg_dio_oe,
  input  wire logic              debug_host_attached,
  output logic                   dbg_clk,
  output logic                   dbg_dio_in,
  output logic                   dbg_enabled,
  // Analog and wake status
  input  wire logic              reference_on_indicator,
  input  wire logic              power_woken_up,
  input  wire logic              wake_event,
  input  wire logic              mirror_active,
  input  wire logic              pwr_seq_start,
  input  wire logic              analog_ready,
  // Power and reset controls
  output logic                   radio_powerdown,
  output logic                   timer_domain_powerdown,
  output logic [1:0]             mirror_clk_div,
  output logic                   hw_reset_req,
  output logic                   software_device_reset,
  output logic                   pwr_seq_done
);

  // Register storage
  logic [15:0] puc_q;
  logic [15:0] sc_q;
  logic        wait_q;
  logic        hw_rst_q;
  logic        sw_rst_q;

  // Sequencer status
  wire seq_busy;
  wire seq_done;
  wire seq_timed_out;

  // Address decode for mapped registers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
    hit = (a == idx[ADDR_W-1:0]);
  endfunction : hit

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (cur & ~lanes) | (wd & lanes);
  endfunction : merge

  // Bus request qualifiers
  wire        req      = avs_read || avs_write;
  wire        accept   = req && !wait_q;
  wire        hit_puc  = hit(avs_address, PUC_IDX);
  wire        hit_sc   = hit(avs_address, SC_IDX);
  wire        hit_stat = hit(avs_address, STAT_IDX);
  wire        wr_puc   = accept && avs_write && hit_puc;
  wire        wr_sc    = accept && avs_write && hit_sc;
  wire [15:0] wdata    = avs_writedata[15:0];

  // R7 write-one to bit 15 fires reset
  wire sw_rst_hit = wr_sc && avs_byteenable[1] && wdata[SC_SWRST_BIT];

  // R6 wake with reset-after-wake set
  wire hw_rst_hit = wake_event && puc_q[PUC_RAW_BIT];

  // Named fields
  wire       wake_diag_pin_map = puc_q[PUC_DIAG_BIT];
  wire [1:0] dbg_sel           = sc_q[SC_DBG_LSB +: 2];
  wire       timeout_disable   = sc_q[SC_TMO_BIT];

  // R12 status word, read only
  wire [15:0] stat_word;
  assign stat_word = 16'((32'(seq_timed_out) << STAT_TMO_BIT)
                   | (32'(debug_host_attached) << STAT_DBG_BIT)
                   | (32'(!puc_q[PUC_TIMER_BIT]) << STAT_TUP_BIT)
                   | (32'(puc_q[PUC_TIMER_BIT]) << STAT_TDN_BIT)
                   | (32'(!puc_q[PUC_RADIO_BIT]) << STAT_RUP_BIT)
                   | (32'(puc_q[PUC_RADIO_BIT]) << STAT_RDN_BIT));

  // Read mux; unmapped reads return zero, bit 15 of system control reads zero
  wire [15:0] rd_sel;
  assign rd_sel = hit_puc  ? (puc_q & PUC_RW_MASK) :
                  hit_sc   ? (sc_q & SC_RW_MASK)   :
                  hit_stat ? stat_word             : 16'h0000;

  // One wait state: waitrequest drops for exactly one cycle per request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wait_q <= 1'b1;
    else
      wait_q <= !(req && wait_q);
  end

  // Read data captured while waitrequest is high, stands in the answer cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (req && wait_q && avs_read)
      avs_readdata <= {16'h0000, rd_sel};
  end

  assign avs_waitrequest = wait_q;

  // Reset pulses; held one cycle so the resets below follow them
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hw_rst_q <= 1'b0;
      sw_rst_q <= 1'b0;
    end
    else
    begin
      hw_rst_q <= hw_rst_hit;
      sw_rst_q <= sw_rst_hit;
    end
  end

  // R7 power unit control falls back to reset on either reset pulse
  // R13 reserved bits kept in storage but drive nothing
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || hw_rst_q || sw_rst_q)
      puc_q <= PUC_RESET;
    else if (wr_puc)
      puc_q <= merge(puc_q, wdata, avs_byteenable[1:0], PUC_RW_MASK);
  end

  // R7 system control is spared by the software reset
  // R10 debug field written by boot code, zero after reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || hw_rst_q)
      sc_q <= SC_RESET;
    else if (wr_sc)
      sc_q <= merge(sc_q, wdata, avs_byteenable[1:0], SC_RW_MASK);
  end

  // R8 analog start-up wait with timeout
  psc_pwr_seq #(
    .CNT_W   (CNT_W),
    .TMO_CYC (TMO_CYC)
  ) u_seq (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .start           (pwr_seq_start),
    .analog_ready    (analog_ready),
    .timeout_disable (timeout_disable),
    .busy            (seq_busy),
    .done            (seq_done),
    .timed_out       (seq_timed_out)
  );

  // R9 data pin index for each debug code
  function automatic int dio_pin(input logic [1:0] sel);
    case (sel)
      DBG_PIN5:  dio_pin = 5;
      DBG_PIN1:  dio_pin = 1;
      DBG_PIN10: dio_pin = 10;
      default:   dio_pin = -1;
    endcase
  endfunction : dio_pin

  // R10 debug routing only when the field is nonzero
  wire dbg_on = (dbg_sel != DBG_OFF);
  wire dbg_dio_in_d;
  assign dbg_dio_in_d = (dio_pin(dbg_sel) >= 0) ? p0_in[dio_pin(dbg_sel)] : 1'b0;

  // Per-pin output selection
  logic [NUM_P0-1:0] out_d;
  logic [NUM_P0-1:0] oe_d;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_P0; gi++)
    begin : g_pin
      // R9 data pin and clock pin taken from GPIO while debug is on
      // R11 code three lands on pin 10 through the same lookup
      wire is_dio = dbg_on && (dio_pin(dbg_sel) == gi);
      wire is_clk = dbg_on && (gi == CLK_PIN);
      // R1 diagnostic map overrides both; host should be gone by then
      wire is_diag = wake_diag_pin_map && (gi == CLK_PIN || gi == WOKE_PIN);
      wire diag_val = (gi == CLK_PIN) ? reference_on_indicator : power_woken_up;
      assign out_d[gi] = is_diag ? diag_val :
                         is_dio  ? dbg_dio_out :
                         is_clk  ? 1'b0 : gpio_out[gi];
      assign oe_d[gi]  = is_diag ? 1'b1 :
                         is_dio  ? dbg_dio_oe :
                         is_clk  ? 1'b0 : gpio_oe[gi];
    end
  endgenerate

  // Pad and debug-side registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      p0_out      <= '0;
      p0_oe       <= '0;
      gpio_in     <= '0;
      dbg_clk     <= 1'b0;
      dbg_dio_in  <= 1'b0;
      dbg_enabled <= 1'b0;
    end
    else
    begin
      p0_out      <= out_d;
      p0_oe       <= oe_d;
      gpio_in     <= p0_in;
      dbg_clk     <= dbg_on ? p0_in[CLK_PIN] : 1'b0;
      dbg_dio_in  <= dbg_dio_in_d;
      dbg_enabled <= dbg_on;
    end
  end

  // Power and reset outputs
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      radio_powerdown        <= 1'b1;
      timer_domain_powerdown <= 1'b1;
      mirror_clk_div         <= 2'h0;
      hw_reset_req           <= 1'b0;
      software_device_reset  <= 1'b0;
      pwr_seq_done           <= 1'b0;
    end
    else
    begin
      // R4 radio held down while bit is one
      radio_powerdown        <= puc_q[PUC_RADIO_BIT];
      // R5 timer domain held down while bit is one
      timer_domain_powerdown <= puc_q[PUC_TIMER_BIT];
      // R3 divider applies only during mirroring
      mirror_clk_div         <= mirror_active ? puc_q[PUC_DIV_LSB +: 2] : 2'h0;
      // R6 hardware reset request after wake
      hw_reset_req           <= hw_rst_hit;
      // R7 device-wide software reset pulse
      software_device_reset  <= sw_rst_hit;
      pwr_seq_done           <= seq_done && !seq_busy;
    end
  end

endmodule : psc_top

// File: test/psc_assertions.sv
// Purpose: Port-level checks on psc_top.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Power outputs lag their register by one clock.
module psc_chk
  import psc_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // Bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_write,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_writedata,
  input wire logic              avs_waitrequest,
  // Controls
  input wire logic              wake_event,
  input wire logic              mirror_active,
  input wire logic [1:0]        mirror_clk_div,
  input wire logic              hw_reset_req,
  input wire logic              software_device_reset,
  input wire logic              radio_powerdown,
  input wire logic              timer_domain_powerdown,
  input wire logic              dbg_enabled,
  input wire logic              dbg_clk,
  input wire logic              pwr_seq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Accepted write of the reset bit; needs the upper byte lane
  wire sw_hit = avs_write && !avs_waitrequest && avs_byteenable[1]
    && avs_address == SC_IDX[ADDR_W-1:0] && avs_writedata[SC_SWRST_BIT];
  wire both_pd = radio_powerdown && timer_domain_powerdown;
  sw_pulse_a: assert property (sw_hit |=> software_device_reset)
    else $error("reset bit write gave no pulse");
  sw_effect_a: assert property (software_device_reset |-> ##[1:3] both_pd)
    else $error("software reset kept power bits");
  wake_cause_a: assert property (hw_reset_req |-> $past(wake_event))
    else $error("hardware reset without wake");
  wake_effect_a: assert property (hw_reset_req |-> ##[1:3] both_pd)
    else $error("wake reset kept power bits");
  div_idle_a: assert property (!mirror_active |=> mirror_clk_div == 2'h0)
    else $error("divider outside mirroring");
  // Output moves two edges after the accepted write or the reset pulse
  pd_cause_a: assert property ($changed({radio_powerdown, timer_domain_powerdown})
    |-> $past(avs_write && !avs_waitrequest, 2)
      || $past(software_device_reset || hw_reset_req, 2))
    else $error("power bit moved without write");
  dbg_off_a: assert property (!dbg_enabled && $past(!dbg_enabled) |-> !dbg_clk)
    else $error("debug clock while disabled");
  done_pulse_a: assert property (pwr_seq_done |=> !pwr_seq_done)
    else $error("sequencer done longer than a cycle");
endmodule : psc_chk

// File: test/psc_swd_host.sv
// Purpose: Behavioural debug host on the shared clock and data pins.
// Assumes: Clock runs at an eighth of the ref_clk rate while attached.
// Notes:   A released data line toggles so stale values never pass.
module psc_swd_host
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control and pins
  input wire logic attach,
  output logic     swclk,
  output logic     swdio,
  output logic     attached
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q;
  assign attached = attach;
  always_ff @(posedge ref_clk)
  begin
    div_q <= rst_n ? div_q + 2'h1 : 2'h0;
    swclk <= (attach && rst_n) ? (swclk ^ (div_q == 2'h3)) : 1'b0;
    swdio <= !rst_n ? 1'b0 : (attach ? div_q[1] : !swdio);
  end
endmodule : psc_swd_host

// File: test/psc_top_tb.sv
// Purpose: Self-checking bench for psc_top.
// Assumes: Sequencer timeout shortened to 20 cycles.
// Notes:   Read data is checked against a queue of expected words.
module psc_top_tb
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 20;
  localparam logic [7:0] A_PUC = PUC_IDX[7:0];
  localparam logic [7:0] A_SC = SC_IDX[7:0];
  localparam logic [7:0] A_ST = STAT_IDX[7:0];
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, wake_event, mirror_active;
  logic pwr_seq_start, analog_ready, reference_on_indicator, power_woken_up, host_attach;
  logic dbg_dio_out, dbg_dio_oe, debug_host_attached, dbg_clk, dbg_dio_in, dbg_enabled;
  logic radio_powerdown, timer_domain_powerdown, hw_reset_req, software_device_reset;
  logic pwr_seq_done, swclk, swdio;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, lfsr_q;
  logic [10:0] rnd, gpio_out, gpio_oe, gpio_in, p0_out, p0_oe;
  logic [1:0] mirror_clk_div;
  logic [15:0] expq[$];
  int err_count, total_checks;
  // Pad levels resolved from both drivers
  wire [10:0] p0_in = {rnd[10:6], p0_oe[5] ? p0_out[5] : swdio, rnd[4:3],
    p0_oe[2] ? p0_out[2] : swclk, rnd[1:0]};
  psc_top #(.TMO_CYC(TMO)) uut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .p0_in, .p0_out,
    .p0_oe, .gpio_out, .gpio_oe, .gpio_in, .dbg_dio_out, .dbg_dio_oe, .debug_host_attached,
    .dbg_clk, .dbg_dio_in, .dbg_enabled, .reference_on_indicator, .power_woken_up,
    .wake_event, .mirror_active, .pwr_seq_start, .analog_ready, .radio_powerdown,
    .timer_domain_powerdown, .mirror_clk_div, .hw_reset_req, .software_device_reset,
    .pwr_seq_done);
  psc_swd_host host (.ref_clk, .rst_n, .attach(host_attach), .swclk, .swdio,
    .attached(debug_host_attached));
  // Free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic tmo();
    $display("CHECK FAILED t=%0t wait ran out", $time);
    err_count++;
    finish_test();
  endtask : tmo
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; a read notes its expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    if (!w)
      expq.push_back(d);
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      tmo();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pwr_seq_done !== 1'b1 && n < 200);
    if (n >= 200)
      tmo();
  endtask : wait_done
  task automatic kick();
    pwr_seq_start <= 1'b1;
    @(posedge ref_clk);
    pwr_seq_start <= 1'b0;
  endtask : kick
  // Read data against the oldest note
  always @(posedge ref_clk)
    if (avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata[15:0], expq.pop_front());
  // Main sequence
  initial
  begin
    int n;
    logic [15:0] v;
    logic [1:0] s;
    err_count = 0;
    total_checks = 0;
    lfsr_q = 32'h740DE2C4;
    {rst_n, avs_read, avs_write, wake_event, mirror_active, pwr_seq_start} = 6'h00;
    {analog_ready, power_woken_up, host_attach, dbg_dio_oe} = 4'h1;
    {reference_on_indicator, dbg_dio_out} = 2'h3;
    {avs_address, avs_writedata, rnd, gpio_out, gpio_oe} = '0;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, A_PUC, PUC_RESET);
    bus(1'b0, A_SC, SC_RESET);
    bus(1'b0, A_ST, 16'h0005);
    bus(1'b0, 8'h20, 16'h0000);
    // Random stored bits
    repeat (3)
    begin
      lfsr_q = lfsr(lfsr_q);
      rnd <= lfsr_q[31:21];
      v = lfsr_q[15:0] & 16'h07FF;
      bus(1'b1, A_PUC, v);
      bus(1'b0, A_PUC, v & PUC_RW_MASK);
      bus(1'b1, A_SC, v);
      bus(1'b0, A_SC, v & SC_RW_MASK);
    end
    bus(1'b1, A_PUC, 16'h0030);
    mirror_active <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(radio_powerdown, 1'b0);
    chk(timer_domain_powerdown, 1'b0);
    chk(mirror_clk_div, 2'h3);
    mirror_active <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(mirror_clk_div, 2'h0);
    // Every debug routing code with the host attached
    host_attach <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      lfsr_q = lfsr(lfsr_q);
      gpio_out <= lfsr_q[10:0];
      gpio_oe <= lfsr_q[21:11];
      bus(1'b1, A_SC, 16'(c << SC_DBG_LSB));
      repeat (2) @(posedge ref_clk);
      n = c == 1 ? 5 : (c == 2 ? 1 : 10);
      chk(dbg_enabled, c != 0);
      if (c == 0)
      begin
        chk(p0_oe, gpio_oe);
        // Pins 2 and 5 carry the host's lines, which change every two or four clocks
        chk(gpio_in & 11'h7DB, p0_in & 11'h7DB);
      end
      else
        chk({p0_oe[CLK_PIN], p0_oe[n], p0_out[n]}, 3'h3);
    end
    // Host drives both pins on code one
    dbg_dio_oe <= 1'b0;
    bus(1'b1, A_SC, 16'h0080);
    repeat (8)
    begin
      @(posedge ref_clk);
      #1 s = {p0_in[5], p0_in[CLK_PIN]};
      @(posedge ref_clk);
      #1 chk({dbg_dio_in, dbg_clk}, s);
    end
    bus(1'b0, A_ST, 16'h001A);
    // Host leaves before diagnostics take the clock pin
    host_attach <= 1'b0;
    bus(1'b1, A_PUC, 16'h0040);
    repeat (2) @(posedge ref_clk);
    chk(p0_oe[2:1], 2'h3);
    chk(p0_out[2:1], {reference_on_indicator, power_woken_up});
    bus(1'b1, A_PUC, 16'h0001);
    wake_event <= 1'b1;
    @(posedge ref_clk);
    wake_event <= 1'b0;
    @(posedge ref_clk);
    chk(hw_reset_req, 1'b1);
    bus(1'b0, A_PUC, PUC_RESET);
    bus(1'b0, A_SC, SC_RESET);
    // Software reset spares system control
    bus(1'b1, A_SC, 16'h0480);
    bus(1'b1, A_PUC, 16'h0000);
    bus(1'b1, A_SC, 16'h8480);
    @(posedge ref_clk);
    chk(software_device_reset, 1'b1);
    bus(1'b0, A_PUC, PUC_RESET);
    bus(1'b0, A_SC, 16'h0480);
    // Sequencer waits forever, then times out
    analog_ready <= 1'b0;
    kick();
    // Done is a one-cycle pulse, so every edge of the wait is watched
    n = 0;
    repeat (3 * TMO)
    begin
      @(posedge ref_clk);
      n += int'(pwr_seq_done === 1'b1);
    end
    chk(16'(n), 16'h0000);
    analog_ready <= 1'b1;
    wait_done(n);
    chk(n >= 2 && n <= 4, 1'b1);
    analog_ready <= 1'b0;
    bus(1'b1, A_SC, 16'h0000);
    kick();
    wait_done(n);
    chk(n >= TMO && n <= TMO + 4, 1'b1);
    bus(1'b0, A_ST, 16'h0105);
    finish_test();
  end
endmodule : psc_top_tb
bind psc_top psc_chk #(.ADDR_W(ADDR_W)) chk_i (.ref_clk, .rst_n, .avs_address, .avs_write,
  .avs_byteenable, .avs_writedata, .avs_waitrequest, .wake_event, .mirror_active,
  .mirror_clk_div, .hw_reset_req, .software_device_reset, .radio_powerdown,
  .timer_domain_powerdown, .dbg_enabled, .dbg_clk, .pwr_seq_done);
